// ===== gie_exec.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gie_exec
    import gie_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        instr_valid,
    input  wire logic [0:15] instr,
    input  wire logic        cmp_word_valid,
    input  wire logic [0:15] cmp_word_operand,
    input  wire logic [0:15] io_in_data,
    input  wire logic        external_sense,
    input  wire logic [0:3]  sense_switch,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             busy,
    output logic             done,
    output logic             skip_taken,
    output logic      [0:14] program_counter,
    output logic      [0:7]  io_addr,
    output logic      [0:15] io_out_data,
    output logic             io_in_strobe,
    output logic             io_out_strobe
);
    typedef struct packed {
        gie_state_t  state;
        logic [7:0]  count;
        logic [0:15] accumulator;
        logic [0:15] index_register;
        logic [0:14] program_counter;
        logic        compare_less_flag;
        logic        compare_equal_flag;
        logic        overflow_flag;
        logic        illegal;
        logic        skip_taken;
        logic        done;
        logic        busy;
        logic        is_input;
        logic        in_strobe;
        logic        out_strobe;
        logic [0:7]  io_addr;
        logic [0:15] io_out;
        logic [15:0] rdata;
        logic [0:15] din_s1;
        logic [0:15] din_s2;
        logic [0:4]  sense_s1;
        logic [0:4]  sense_s2;
    } gie_st_t;

    gie_st_t r_reg;
    gie_st_t r_next;

    logic [3:0]  f_opc;
    logic [3:0]  f_cls;
    logic [3:0]  f_sub;
    logic [0:7]  lit;
    logic [0:15] idx_inc;
    logic [0:15] idx_dec;
    logic        accept;
    logic        sense_ext;
    logic [0:3]  sw;

    assign f_opc     = instr[OPC_MSB:OPC_LSB];
    assign f_cls     = instr[CLS_MSB:CLS_LSB];
    assign f_sub     = instr[SUB_MSB:SUB_LSB];
    assign lit       = instr[SUB_MSB:FUN_LSB];
    assign idx_inc   = r_reg.index_register + {8'h00, lit};
    assign idx_dec   = r_reg.index_register - {8'h00, lit};
    assign accept    = instr_valid && (r_reg.state == ST_IDLE);
    assign sense_ext = r_reg.sense_s2[0];
    assign sw        = r_reg.sense_s2[1:4];

    always_comb begin
        logic cond;
        logic legal;
        cond = 1'b0;
        legal = 1'b1;
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.rdata = 16'h0000;
        // Input data and sense pins cross in through two flops before anything looks at them
        r_next.din_s1 = io_in_data;
        r_next.din_s2 = r_reg.din_s1;
        r_next.sense_s1 = {external_sense, sense_switch};
        r_next.sense_s2 = r_reg.sense_s1;

        if (reg_rd) begin
            case (reg_addr)
                REG_ACC:    r_next.rdata = r_reg.accumulator;
                REG_INDEX:  r_next.rdata = r_reg.index_register;
                REG_PC:     r_next.rdata = {1'b0, r_reg.program_counter};
                REG_FLAGS:  r_next.rdata = {13'h0000, r_reg.overflow_flag, r_reg.compare_equal_flag,
                                            r_reg.compare_less_flag};
                REG_STATUS: r_next.rdata = {13'h0000, r_reg.skip_taken, r_reg.illegal, r_reg.busy};
                default:    r_next.rdata = 16'h0000;
            endcase
        end
        // Software writes land first so that instruction results in the same cycle win
        if (reg_wr) begin
            case (reg_addr)
                REG_ACC:   r_next.accumulator = reg_wdata;
                REG_INDEX: r_next.index_register = reg_wdata;
                REG_PC:    r_next.program_counter = reg_wdata[14:0];
                REG_FLAGS: begin
                    r_next.compare_less_flag = reg_wdata[FLAG_LESS];
                    r_next.compare_equal_flag = reg_wdata[FLAG_EQUAL];
                    r_next.overflow_flag = reg_wdata[FLAG_OVF];
                end
                default: ;
            endcase
        end
        if (cmp_word_valid) begin
            r_next.compare_less_flag = $signed(r_reg.accumulator) < $signed(cmp_word_operand);
            r_next.compare_equal_flag = r_reg.accumulator == cmp_word_operand;
        end

        case (r_reg.state)
            ST_IDLE: begin
                if (accept) begin
                    legal = (f_opc == NONMEMORY_OPCODE);
                    case (f_cls)
                        CLS_DATA: begin
                            case (f_sub)
                                CLEAR_ACC_OP: r_next.accumulator = 16'h0000;
                                NEGATE_ACC_OP: begin
                                    r_next.accumulator = 16'h0000 - r_reg.accumulator;
                                    if (r_reg.accumulator == MOST_NEGATIVE) begin
                                        r_next.overflow_flag = 1'b1;
                                    end
                                end
                                ONES_COMPLEMENT_ACC_OP: r_next.accumulator = ~r_reg.accumulator;
                                COPY_INDEX_TO_ACC_OP: r_next.accumulator = r_reg.index_register;
                                COPY_ACC_TO_INDEX_OP: r_next.index_register = r_reg.accumulator;
                                default: legal = 1'b0;
                            endcase
                        end
                        CLS_INPUT, CLS_OUTPUT: begin
                            // Device in bits 8-11, function in 12-15, both sent as one byte
                            r_next.io_addr = instr[SUB_MSB:FUN_LSB];
                            r_next.is_input = (f_cls == CLS_INPUT);
                            r_next.in_strobe = (f_cls == CLS_INPUT);
                            r_next.out_strobe = (f_cls == CLS_OUTPUT);
                            if (f_cls == CLS_OUTPUT) begin
                                r_next.io_out = r_reg.accumulator;
                            end
                            r_next.count = 8'h00;
                            r_next.busy = 1'b1;
                            r_next.state = ST_STROBE;
                        end
                        CLS_INC_SKIP: begin
                            r_next.index_register = idx_inc;
                            cond = !idx_inc[SIGN_POS];
                        end
                        CLS_DEC_SKIP: begin
                            r_next.index_register = idx_dec;
                            cond = idx_dec[SIGN_POS];
                        end
                        CLS_LOAD_BYTE: r_next.accumulator[BYTE_HI:LSB_POS] = lit;
                        CLS_CMP_BYTE: begin
                            r_next.compare_less_flag =
                                $signed(r_reg.accumulator[BYTE_HI:LSB_POS]) < $signed(lit);
                            r_next.compare_equal_flag = r_reg.accumulator[BYTE_HI:LSB_POS] == lit;
                        end
                        CLS_SKIP: begin
                            case (f_sub)
                                SKIP_ACC_ZERO_OP:  cond = r_reg.accumulator == 16'h0000;
                                SKIP_ACC_PLUS_OP:  cond = !r_reg.accumulator[SIGN_POS];
                                SKIP_ACC_MINUS_OP: cond = r_reg.accumulator[SIGN_POS];
                                SKIP_ACC_ODD_OP:   cond = r_reg.accumulator[LSB_POS];
                                SKIP_CMP_LESS_OP:  cond = r_reg.compare_less_flag;
                                SKIP_INDEX_EVEN_OP: cond = !r_reg.index_register[LSB_POS];
                                SKIP_CMP_EQUAL_OP: cond = r_reg.compare_equal_flag;
                                SKIP_CMP_NOT_EQUAL_OP: cond = !r_reg.compare_equal_flag;
                                SKIP_CMP_GREATER_OP:
                                    cond = !r_reg.compare_less_flag && !r_reg.compare_equal_flag;
                                SKIP_CMP_LESS_OR_EQUAL_OP:
                                    cond = r_reg.compare_less_flag || r_reg.compare_equal_flag;
                                SKIP_NO_OVERFLOW_OP: begin
                                    cond = !r_reg.overflow_flag;
                                    r_next.overflow_flag = 1'b0;
                                end
                                EXTERNAL_SENSE_TEST:     cond = !sense_ext;
                                SENSE_SWITCH_ZERO_TEST:  cond = !sw[0];
                                SENSE_SWITCH_ONE_TEST:   cond = !sw[1];
                                SENSE_SWITCH_TWO_TEST:   cond = !sw[2];
                                SENSE_SWITCH_THREE_TEST: cond = !sw[3];
                                default: cond = 1'b0;
                            endcase
                        end
                        default: legal = 1'b0;
                    endcase
                    if (!legal) begin
                        // Foreign or unsupported words change nothing but the counter and the status bits, and drop any register write, read or word compare of the same cycle
                        r_next = r_reg;
                        r_next.done = 1'b0;
                        r_next.rdata = 16'h0000;
                        r_next.din_s1 = io_in_data;
                        r_next.din_s2 = r_reg.din_s1;
                        r_next.sense_s1 = {external_sense, sense_switch};
                        r_next.sense_s2 = r_reg.sense_s1;
                        cond = 1'b0;
                    end
                    if (!legal || r_next.state == ST_IDLE) begin
                        r_next.done = 1'b1;
                        r_next.illegal = !legal;
                        r_next.skip_taken = cond;
                        r_next.program_counter = r_reg.program_counter + (cond ? PC_SKIP_STEP : PC_STEP);
                    end
                end
            end
            ST_STROBE: begin
                if (r_reg.count == 8'(STROBE_CYCLES - 1)) begin
                    if (r_reg.is_input) begin
                        // Peripheral holds data through the trailing edge, so the synced copy is settled
                        r_next.accumulator = r_reg.din_s2;
                    end
                    r_next.in_strobe = 1'b0;
                    r_next.out_strobe = 1'b0;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                    r_next.illegal = 1'b0;
                    r_next.skip_taken = 1'b0;
                    r_next.program_counter = r_reg.program_counter + PC_STEP;
                    r_next.state = ST_IDLE;
                end else begin
                    r_next.count = r_reg.count + 8'h01;
                end
            end
            default: r_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata       = r_reg.rdata;
    assign busy            = r_reg.busy;
    assign done            = r_reg.done;
    assign skip_taken      = r_reg.skip_taken;
    assign program_counter = r_reg.program_counter;
    assign io_addr         = r_reg.io_addr;
    assign io_out_data     = r_reg.io_out;
    assign io_in_strobe    = r_reg.in_strobe;
    assign io_out_strobe   = r_reg.out_strobe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic gen_ok;
    assign gen_ok = accept && (f_opc == NONMEMORY_OPCODE);

    property p_clear;
        gen_ok && f_cls == CLS_DATA && f_sub == CLEAR_ACC_OP |=> r_reg.accumulator == 16'h0000 && done;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero accumulator");

    property p_negate;
        gen_ok && f_cls == CLS_DATA && f_sub == NEGATE_ACC_OP |=>
            r_reg.accumulator == 16'h0000 - $past(r_reg.accumulator)
            && ($past(r_reg.accumulator) != MOST_NEGATIVE || r_reg.overflow_flag);
    endproperty
    a_negate: assert property (p_negate) else $error("negate result or overflow wrong");

    property p_invert;
        gen_ok && f_cls == CLS_DATA && f_sub == ONES_COMPLEMENT_ACC_OP |=>
            r_reg.accumulator == ~$past(r_reg.accumulator);
    endproperty
    a_invert: assert property (p_invert) else $error("invert result wrong");

    property p_copy_a2x;
        gen_ok && f_cls == CLS_DATA && f_sub == COPY_ACC_TO_INDEX_OP |=>
            r_reg.index_register == $past(r_reg.accumulator) && r_reg.accumulator == $past(r_reg.accumulator);
    endproperty
    a_copy_a2x: assert property (p_copy_a2x) else $error("copy to index wrong");

    sequence s_in_strobe;
        io_in_strobe [*3] ##1 (!io_in_strobe && done);
    endsequence
    property p_input;
        gen_ok && f_cls == CLS_INPUT |=> s_in_strobe;
    endproperty
    a_input: assert property (p_input) else $error("input strobe sequence wrong");

    sequence s_out_strobe;
        (io_out_strobe && !io_in_strobe) [*3] ##1 (!io_out_strobe && done);
    endsequence
    property p_output;
        gen_ok && f_cls == CLS_OUTPUT |=> (io_out_data == $past(r_reg.accumulator)
            && io_addr == $past(instr[SUB_MSB:FUN_LSB])) ##0 s_out_strobe;
    endproperty
    a_output: assert property (p_output) else $error("output address, data or strobe wrong");

    property p_inc_skip;
        gen_ok && f_cls == CLS_INC_SKIP |=>
            r_reg.index_register == $past(idx_inc) && skip_taken == !r_reg.index_register[SIGN_POS];
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment and skip wrong");

    property p_load_byte;
        gen_ok && f_cls == CLS_LOAD_BYTE |=> r_reg.accumulator == {$past(r_reg.accumulator[0:7]), $past(lit)};
    endproperty
    a_load_byte: assert property (p_load_byte) else $error("literal byte load wrong");

    property p_no_ovf;
        gen_ok && f_cls == CLS_SKIP && f_sub == SKIP_NO_OVERFLOW_OP |=>
            !r_reg.overflow_flag && skip_taken == !$past(r_reg.overflow_flag);
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("no-overflow test wrong");

    property p_pc_step;
        done |-> program_counter == $past(r_reg.program_counter) + (skip_taken ? PC_SKIP_STEP : PC_STEP)
            || $past(reg_wr);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");
endmodule // gie_exec
`default_nettype wire

// ===== gie_periph.sv
`timescale 1ns/1ps
`default_nettype none
module gie_periph (
    input  wire logic        clk,
    input  wire logic [0:7]  io_addr,
    input  wire logic [0:15] io_out_data,
    input  wire logic        io_in_strobe,
    input  wire logic        io_out_strobe,
    output logic      [0:15] io_in_data,
    output logic      [0:7]  cap_addr,
    output logic      [0:15] cap_data
);
    logic tog = 1'b0;
    // Outside a strobe the bus churns, so a late sample never sees stale data
    always @(posedge clk) tog <= ~tog;
    assign io_in_data = io_in_strobe ? {io_addr, ~io_addr} : {16{tog}} ^ 16'ha5c3;
    always @(posedge clk) begin
        if (io_out_strobe) begin
            cap_addr <= io_addr;
            cap_data <= io_out_data;
        end
    end
endmodule // gie_periph
`default_nettype wire

// ===== gie_pkg.sv
// Function
// - Clear loads the accumulator with zero.
// - Negate takes two's complement; most negative operand sets overflow.
// - Ones-complement inverts every accumulator bit.
// - Copies move index to accumulator or back, source left unchanged.
// - Direct input drives address, strobes, loads accumulator at strobe trailing edge.
// - Direct output drives address and accumulator, strobes; accumulator unchanged.
// - Address bits 8-11 select device, bits 12-15 select function.
// - Increment adds unsigned literal to index; skip when result not negative.
// - Decrement subtracts unsigned literal from index; skip when result negative.
// - Literal byte load writes accumulator bits 8-15, keeps bits 0-7.
// - Literal compare sets less and equal flags from signed byte difference.
// - Accumulator tests skip on zero, plus or minus; accumulator untouched.
// - Odd test skips when accumulator bit 15 is one.
// - Index even test skips when index bit 15 is zero.
// - Less, equal, not-equal tests skip from the compare flags.
// - Greater skips when both flags clear; less-or-equal when either set.
// - No-overflow test skips on clear overflow, then always clears it.
// - External sense test skips when the sense input is false.
// - Each of four sense switch tests skips when its switch is false.
// - Generics share opcode bits 0-3; bits 4-7 class, 8-11 subclass.
// - Word compare sets less and equal flags from signed 16-bit difference.
package gie_pkg;
    // Bit numbering runs 0 (most significant) to 15 (least significant)
    localparam int OPC_MSB = 0;
    localparam int OPC_LSB = 3;
    localparam int CLS_MSB = 4;
    localparam int CLS_LSB = 7;
    localparam int SUB_MSB = 8;
    localparam int SUB_LSB = 11;
    localparam int FUN_MSB = 12;
    localparam int FUN_LSB = 15;
    localparam int BYTE_HI = 8;
    localparam int LSB_POS = 15;
    localparam int SIGN_POS = 0;

    localparam logic [3:0] NONMEMORY_OPCODE = 4'h0;
    localparam logic [3:0] CLS_DATA         = 4'h1;
    localparam logic [3:0] CLS_INPUT        = 4'h2;
    localparam logic [3:0] CLS_OUTPUT       = 4'h3;
    localparam logic [3:0] CLS_INC_SKIP     = 4'h4;
    localparam logic [3:0] CLS_DEC_SKIP     = 4'h5;
    localparam logic [3:0] CLS_LOAD_BYTE    = 4'h6;
    localparam logic [3:0] CLS_CMP_BYTE     = 4'h7;
    localparam logic [3:0] CLS_SKIP         = 4'h8;

    localparam logic [3:0] CLEAR_ACC_OP          = 4'h0;
    localparam logic [3:0] NEGATE_ACC_OP         = 4'h1;
    localparam logic [3:0] ONES_COMPLEMENT_ACC_OP = 4'h2;
    localparam logic [3:0] COPY_INDEX_TO_ACC_OP  = 4'h3;
    localparam logic [3:0] COPY_ACC_TO_INDEX_OP  = 4'h4;

    localparam logic [3:0] SKIP_ACC_ZERO_OP          = 4'h0;
    localparam logic [3:0] SKIP_ACC_PLUS_OP          = 4'h1;
    localparam logic [3:0] SKIP_ACC_MINUS_OP         = 4'h2;
    localparam logic [3:0] SKIP_ACC_ODD_OP           = 4'h3;
    localparam logic [3:0] SKIP_CMP_LESS_OP          = 4'h4;
    localparam logic [3:0] SKIP_INDEX_EVEN_OP        = 4'h5;
    localparam logic [3:0] SKIP_CMP_EQUAL_OP         = 4'h6;
    localparam logic [3:0] SKIP_CMP_NOT_EQUAL_OP     = 4'h7;
    localparam logic [3:0] SKIP_CMP_GREATER_OP       = 4'h8;
    localparam logic [3:0] SKIP_CMP_LESS_OR_EQUAL_OP = 4'h9;
    localparam logic [3:0] SKIP_NO_OVERFLOW_OP       = 4'ha;
    localparam logic [3:0] EXTERNAL_SENSE_TEST       = 4'hb;
    localparam logic [3:0] SENSE_SWITCH_ZERO_TEST    = 4'hc;
    localparam logic [3:0] SENSE_SWITCH_ONE_TEST     = 4'hd;
    localparam logic [3:0] SENSE_SWITCH_TWO_TEST     = 4'he;
    localparam logic [3:0] SENSE_SWITCH_THREE_TEST   = 4'hf;

    localparam logic [15:0] MOST_NEGATIVE = 16'h8000;
    localparam logic [14:0] PC_STEP       = 15'h0001;
    localparam logic [14:0] PC_SKIP_STEP  = 15'h0002;

    localparam logic [2:0] REG_ACC    = 3'h0;
    localparam logic [2:0] REG_INDEX  = 3'h1;
    localparam logic [2:0] REG_PC     = 3'h2;
    localparam logic [2:0] REG_FLAGS  = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam int FLAG_LESS  = 0;
    localparam int FLAG_EQUAL = 1;
    localparam int FLAG_OVF   = 2;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_ILL   = 1;
    localparam int STAT_SKIP  = 2;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_NS     = 12;
    localparam int STROBE_CYC    = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic {
        ST_IDLE   = 1'b0,
        ST_STROBE = 1'b1
    } gie_state_t;
endpackage

// ===== tb_generic_instruction_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_generic_instruction_exec;
    import gie_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, cmp_word_valid = 1'b0, external_sense = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, lt = 1'b0, eq = 1'b0, ov = 1'b0, ill = 1'b0, sk = 1'b0;
    logic        busy, done, skip_taken, io_in_strobe, io_out_strobe;
    logic [0:15] instr = 16'h0, cmp_word_operand = 16'h0, io_in_data, io_out_data, cap_data;
    logic [0:3]  sense_switch = 4'h0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, acc = 16'h0, ix = 16'h0, w, dq[$], rq[$];
    logic [0:14] program_counter, pc = 15'h0;
    logic [0:7]  io_addr, cap_addr;
    logic [31:0] seed = 32'h00016419;
    int          n_mismatch = 0, n_compared = 0, i;

    always #2 clk = ~clk;

    gie_exec dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
        .cmp_word_valid(cmp_word_valid), .cmp_word_operand(cmp_word_operand), .io_in_data(io_in_data),
        .external_sense(external_sense), .sense_switch(sense_switch), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
        .done(done), .skip_taken(skip_taken), .program_counter(program_counter), .io_addr(io_addr),
        .io_out_data(io_out_data), .io_in_strobe(io_in_strobe), .io_out_strobe(io_out_strobe));
    gie_periph periph (.clk(clk), .io_addr(io_addr), .io_out_data(io_out_data), .io_in_strobe(io_in_strobe),
        .io_out_strobe(io_out_strobe), .io_in_data(io_in_data), .cap_addr(cap_addr), .cap_data(cap_data));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task complete_run;
        $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (done === 1'b1) check("pc_skip", {skip_taken, program_counter}, dq.size() ? dq.pop_front() : 16'hx);
        if (rd_d) check("reg_rdata", reg_rdata, rq.size() ? rq.pop_front() : 16'hx);
    end

    // A read passes its expected value in d; accumulator and index writes also update the model
    task bus(input logic wr, input logic [2:0] a, input logic [15:0] d);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) rq.push_back(d);
        if (wr && a == REG_ACC) acc = d;
        if (wr && a == REG_INDEX) ix = d;
        @(posedge clk);
    endtask

    task idle;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        instr_valid <= 1'b0;
        cmp_word_valid <= 1'b0;
        @(posedge clk);
    endtask

    task run(input logic [15:0] v);
        logic [7:0]        b;
        logic signed [8:0] dd;
        logic [15:0]       c;
        int                k;
        b = v[7:0];
        sk = 1'b0;
        ill = v[15:12] != NONMEMORY_OPCODE;
        c = {~sense_switch[3], ~sense_switch[2], ~sense_switch[1], ~sense_switch[0], ~external_sense, ~ov, lt | eq,
             ~lt & ~eq, ~eq, eq, ~ix[0], lt, acc[0], acc[15], ~acc[15], acc == 16'h0};
        if (!ill) case (v[11:8])
            CLS_DATA: case (v[7:4])
                CLEAR_ACC_OP: acc = 16'h0;
                NEGATE_ACC_OP: begin
                    ov |= acc == MOST_NEGATIVE;
                    acc = -acc;
                end
                ONES_COMPLEMENT_ACC_OP: acc = ~acc;
                COPY_INDEX_TO_ACC_OP: acc = ix;
                COPY_ACC_TO_INDEX_OP: ix = acc;
                default: ill = 1'b1;
            endcase
            CLS_INPUT: acc = {b, ~b};
            CLS_OUTPUT: ;
            CLS_INC_SKIP: begin
                ix = ix + b;
                sk = ~ix[15];
            end
            CLS_DEC_SKIP: begin
                ix = ix - b;
                sk = ix[15];
            end
            CLS_LOAD_BYTE: acc[7:0] = b;
            CLS_CMP_BYTE: begin
                dd = $signed(acc[7:0]) - $signed(b);
                lt = dd < 0;
                eq = dd == 0;
            end
            CLS_SKIP: begin
                sk = c[v[7:4]];
                if (v[7:4] == SKIP_NO_OVERFLOW_OP) ov = 1'b0;
            end
            default: ill = 1'b1;
        endcase
        pc = pc + (sk ? PC_SKIP_STEP : PC_STEP);
        dq.push_back({sk, pc});
        instr_valid <= 1'b1;
        instr <= v;
        @(posedge clk);
        if (!ill && (v[11:8] == CLS_INPUT || v[11:8] == CLS_OUTPUT)) begin
            instr_valid <= 1'b0;
            k = 0;
            // Outputs are looked at on the falling edge, where they have settled
            do begin
                @(negedge clk);
                k++;
                if (done !== 1'b1) check("busy", {15'h0000, busy}, 16'h0001);
            end while (done !== 1'b1 && k < 8);
            if (done !== 1'b1) begin
                check("io_done", 16'h0, 16'h1);
                complete_run;
            end
            check("busy_end", {15'h0000, busy}, 16'h0000);
            if (v[11:8] == CLS_OUTPUT) check("out_addr", {8'h00, cap_addr}, {8'h00, b});
            if (v[11:8] == CLS_OUTPUT) check("out_data", cap_data, acc);
            @(posedge clk);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 8; i++) bus(1'b0, i[2:0], 16'h0);
        for (i = 0; i < 512; i++) begin
            seed = lfsr(seed);
            if (i % 8 == 0) begin
                idle;
                external_sense <= seed[20];
                sense_switch <= seed[19:16];
                bus(1'b1, REG_ACC, i % 64 == 0 ? MOST_NEGATIVE : seed[15:0]);
                bus(1'b1, REG_INDEX, seed[31:16]);
                // The compare gets its own cycle so that idle does not cancel it in the same step
                reg_wr <= 1'b0;
                cmp_word_valid <= 1'b1;
                cmp_word_operand <= seed[23:8];
                lt = $signed(acc) < $signed(seed[23:8]);
                eq = acc == seed[23:8];
                @(posedge clk);
                idle;
                bus(1'b0, REG_ACC, acc);
                bus(1'b0, REG_INDEX, ix);
                bus(1'b0, REG_PC, {1'b0, pc});
                bus(1'b0, REG_FLAGS, {13'h0, ov, eq, lt});
                bus(1'b0, REG_STATUS, {13'h0, sk, ill, 1'b0});
                idle;
            end
            w = i < 256 ? {4'h0, i[7:0], seed[3:0]} : seed[15:0];
            if (seed[31:29] != 3'h0) w[15:12] = 4'h0;
            // Negate the most negative value just written, so that overflow really gets set
            if (i % 64 == 0) w = {NONMEMORY_OPCODE, CLS_DATA, NEGATE_ACC_OP, 4'h0};
            run(w);
        end
        idle;
        repeat (4) @(posedge clk);
        // A missing done or read answer leaves notes behind; count them rather than pass
        check("pending_done", 16'(dq.size()), 16'h0000);
        check("pending_read", 16'(rq.size()), 16'h0000);
        complete_run;
    end
endmodule // tb_generic_instruction_exec
`default_nettype wire
